// [rtl/dpram_cfg_defines.vh]
// Offsets, field positions, reset values and option codes for the dual-port memory.
`ifndef DPRAM_CFG_DEFINES_VH
`define DPRAM_CFG_DEFINES_VH

// ----------------------------------------------------------------------
// Register offsets (byte addresses on the register bus)
// ----------------------------------------------------------------------
`define OFS_CTRL 8'h00
`define OFS_STATUS 8'h04
`define OFS_CONFIG 8'h08

// ----------------------------------------------------------------------
// Field positions and reset values
// ----------------------------------------------------------------------
`define CTRL_ARM_SINGLE 0
`define CTRL_ARM_DOUBLE 1
`define STAT_FIXED_A 0
`define STAT_DOUBLE_A 1
`define STAT_FIXED_B 2
`define STAT_DOUBLE_B 3
`define STAT_PEND_SINGLE 4
`define STAT_PEND_DOUBLE 5
`define STAT_RESET 4'h0
`define ARM_RESET 1'b0
`define CFG_BYTE_WE 0
`define CFG_SOFT 1
`define CFG_INJ_LO 2
`define CFG_IN_STAGE 4
`define CFG_OUT_STAGE 5

// ----------------------------------------------------------------------
// Option codes
// ----------------------------------------------------------------------
`define WMODE_WRITE_FIRST 2'h0
`define WMODE_READ_FIRST 2'h1
`define WMODE_NO_CHANGE 2'h2
`define PRIO_CE 1'b0
`define PRIO_SR 1'b1
`define INJ_NONE 2'h0
`define INJ_SINGLE 2'h1
`define INJ_DOUBLE 2'h2
`define INJ_BOTH 2'h3

`endif

// [rtl/ram_port_out.v]
// Output latch and output register of one memory port, with reset priority.
`include "dpram_cfg_defines.vh"

module ram_port_out #(
  parameter WIDTH = 32,
  parameter [1:0] WRITE_MODE = `WMODE_WRITE_FIRST,
  parameter RESET_WINS = `PRIO_CE,
  parameter LATCH_RESET = 1,
  parameter HAS_OUT_REG = 1,
  parameter [WIDTH-1:0] INIT = {WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire rst,
  input wire port_en,
  input wire outreg_en,
  input wire port_rst,
  input wire wr_hit,
  input wire [WIDTH-1:0] old_data,
  input wire [WIDTH-1:0] new_data,
  output wire [WIDTH-1:0] dout
);

  reg [WIDTH-1:0] latch_ff;
  reg [WIDTH-1:0] oreg_ff;
  wire latch_rst;
  wire oreg_rst;

  // ----------------------------------------------------------------------
  // Memory output latch
  // ----------------------------------------------------------------------
  // Without an output register the latch is the output, so it always resets.
  assign latch_rst = port_rst & ((RESET_WINS == `PRIO_SR) | port_en) &
    ((LATCH_RESET != 0) | (HAS_OUT_REG == 0)); // [RULE10] [RULE11] [RULE12] [RULE13]

  always @(posedge sys_clk)
  begin
    if (rst || latch_rst)
    begin
      latch_ff <= INIT; // [RULE7]
    end
    else if (port_en)
    begin
      if (wr_hit)
      begin
        case (WRITE_MODE)
          `WMODE_WRITE_FIRST: latch_ff <= new_data; // [RULE4] [RULE5]
          `WMODE_READ_FIRST: latch_ff <= old_data; // [RULE5]
          `WMODE_NO_CHANGE: latch_ff <= latch_ff; // [RULE5]
          default: latch_ff <= new_data;
        endcase
      end
      else
      begin
        latch_ff <= old_data;
      end
    end
  end

  // ----------------------------------------------------------------------
  // Output register
  // ----------------------------------------------------------------------
  // A latch reset refills the register with the reset value one edge later.
  assign oreg_rst = port_rst & ((RESET_WINS == `PRIO_SR) | outreg_en); // [RULE10] [RULE11]

  always @(posedge sys_clk)
  begin
    if (rst || oreg_rst)
    begin
      oreg_ff <= INIT; // [RULE7]
    end
    else if (outreg_en)
    begin
      oreg_ff <= latch_ff; // [RULE14]
    end
  end

  assign dout = (HAS_OUT_REG != 0) ? oreg_ff : latch_ff;

endmodule // ram_port_out

// [rtl/soft_decode.v]
// Soft correction decoder: two parity-guarded copies, the good one is chosen.
module soft_decode #(
  parameter WIDTH = 32,
  parameter ENABLE = 0
) (
  input wire [2*WIDTH+1:0] word,
  output wire [WIDTH-1:0] data,
  output wire fixed,
  output wire double_err
);

  wire [WIDTH-1:0] copy0;
  wire [WIDTH-1:0] copy1;
  wire ok0;
  wire ok1;

  assign copy0 = word[WIDTH-1:0];
  assign copy1 = word[2*WIDTH:WIDTH+1];
  assign ok0 = ~(^word[WIDTH:0]);
  assign ok1 = ~(^word[2*WIDTH+1:WIDTH+1]);
  assign data = ((ENABLE == 0) || ok0) ? copy0 : copy1; // [RULE16]
  assign fixed = (ENABLE != 0) & ~ok0 & ok1;
  assign double_err = (ENABLE != 0) & ~ok0 & ~ok1;

endmodule // soft_decode

// [rtl/dpram_cfg_top.v]
// Configurable dual-port memory with port reset controls and soft correction.
//
// How it works
// [RULE1] Second port data width is a build parameter from 1 to 4608 bits.
// [RULE2] Second port write and read depths are build parameters, 2 to 128k words.
// [RULE3] Second port address width is a build parameter from 1 to 24 bits.
// [RULE4] Second port has write-first, read-first and no-change write modes.
// [RULE5] On write output shows new data, old data, or holds, per mode.
// [RULE6] Second port enable, output-register enable and reset pins are each optional.
// [RULE7] Second port output starts at and resets to a build-time value.
// [RULE8] Byte writes on the second port follow the first port's single option.
// [RULE9] Second port write-enable vector is 1 to 512 bits, one per byte lane.
// [RULE10] First port reset-or-enable priority option, enable winning by default.
// [RULE11] Second port has the same reset-or-enable priority option, enable default.
// [RULE12] First port latch-reset option: 1 clears latch and register, 0 register only.
// [RULE13] Second port latch-reset option: 1 clears latch and register, 0 register only.
// [RULE14] With latch reset the output shows the reset value for two cycles.
// [RULE15] Error injection type: 0 none, 1 single, 2 double, 3 both.
// [RULE16] Soft error correction in fabric is a build option, 0 absent, 1 present.
// [RULE17] With soft correction, optional first-port input and second-port output stages.
`include "dpram_cfg_defines.vh"

module dpram_cfg_top #(
  parameter DATA_WIDTH = 32, // [RULE1]
  parameter FIRST_PORT_ADDR_WIDTH = 8,
  parameter WRITE_DEPTH_A = 256,
  parameter SECOND_PORT_ADDR_WIDTH = 8,
  parameter WRITE_DEPTH_B = 256,
  parameter READ_DEPTH_B = 256,
  parameter USE_BYTE_WE = 1,
  parameter WE_WIDTH = 4,
  parameter [1:0] FIRST_PORT_WRITE_MODE = `WMODE_WRITE_FIRST,
  parameter [1:0] SECOND_PORT_WRITE_MODE = `WMODE_WRITE_FIRST,
  parameter FIRST_PORT_HAS_ENABLE = 1,
  parameter FIRST_PORT_HAS_OUTREG_ENABLE = 1,
  parameter FIRST_PORT_HAS_RESET = 1,
  parameter SECOND_PORT_HAS_ENABLE = 1,
  parameter SECOND_PORT_HAS_OUTREG_ENABLE = 1,
  parameter SECOND_PORT_HAS_RESET = 1,
  parameter FIRST_PORT_HAS_OUT_REG = 1,
  parameter SECOND_PORT_HAS_OUT_REG = 1,
  parameter FIRST_PORT_RESET_WINS = `PRIO_CE,
  parameter SECOND_PORT_RESET_WINS = `PRIO_CE,
  parameter FIRST_PORT_LATCH_RESET = 1,
  parameter SECOND_PORT_LATCH_RESET = 1,
  parameter [DATA_WIDTH-1:0] FIRST_PORT_POWERON_VALUE = {DATA_WIDTH{1'b0}},
  parameter [DATA_WIDTH-1:0] SECOND_PORT_POWERON_VALUE = {DATA_WIDTH{1'b0}},
  parameter [1:0] ERROR_INJECTION_TYPE = `INJ_NONE,
  parameter SOFT_CORRECTION_SELECT = 0,
  parameter SOFT_CORRECTION_INPUT_STAGE = 0,
  parameter SOFT_CORRECTION_OUTPUT_STAGE = 0
) (
  input wire sys_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_we_i,
  input wire [7:0] wb_adr_i,
  input wire [3:0] wb_sel_i,
  input wire [31:0] wb_dat_i,
  output wire [31:0] wb_dat_o,
  output wire wb_ack_o,
  input wire first_port_enable,
  input wire first_port_outreg_enable,
  input wire first_port_reset,
  input wire [WE_WIDTH-1:0] first_port_we,
  input wire [FIRST_PORT_ADDR_WIDTH-1:0] first_port_addr,
  input wire [DATA_WIDTH-1:0] first_port_din,
  output wire [DATA_WIDTH-1:0] first_port_dout,
  input wire second_port_enable,
  input wire second_port_outreg_enable,
  input wire second_port_reset,
  input wire [WE_WIDTH-1:0] second_port_we,
  input wire [SECOND_PORT_ADDR_WIDTH-1:0] second_port_addr,
  input wire [DATA_WIDTH-1:0] second_port_din,
  output wire [DATA_WIDTH-1:0] second_port_dout
);

  localparam MEM_WIDTH = 2 * DATA_WIDTH + 2;
  localparam SOFT_IN = (SOFT_CORRECTION_SELECT != 0) && (SOFT_CORRECTION_INPUT_STAGE != 0);
  localparam SOFT_OUT = (SOFT_CORRECTION_SELECT != 0) && (SOFT_CORRECTION_OUTPUT_STAGE != 0);

  reg [MEM_WIDTH-1:0] mem [0:WRITE_DEPTH_A-1];

  reg a_en_ff;
  reg [WE_WIDTH-1:0] a_we_ff;
  reg [FIRST_PORT_ADDR_WIDTH-1:0] a_addr_ff;
  reg [DATA_WIDTH-1:0] a_din_ff;
  wire a_en;
  wire [WE_WIDTH-1:0] a_we;
  wire [FIRST_PORT_ADDR_WIDTH-1:0] a_addr;
  wire [DATA_WIDTH-1:0] a_din;
  wire a_regce;
  wire a_rst;
  wire b_en;
  wire b_regce;
  wire b_rst;
  wire a_in_range;
  wire b_wr_range;
  wire b_rd_range;
  wire a_wr;
  wire b_wr;
  wire [MEM_WIDTH-1:0] a_raw;
  wire [MEM_WIDTH-1:0] b_raw;
  wire [DATA_WIDTH-1:0] a_old;
  wire [DATA_WIDTH-1:0] b_old;
  wire [DATA_WIDTH-1:0] a_new;
  wire [DATA_WIDTH-1:0] b_new;
  wire [MEM_WIDTH-1:0] a_enc;
  wire [MEM_WIDTH-1:0] b_enc;
  wire a_fixed;
  wire a_double;
  wire b_fixed;
  wire b_double;
  wire [DATA_WIDTH-1:0] b_core_dout;
  reg [DATA_WIDTH-1:0] b_dout_ff;

  reg arm_single_ff;
  reg arm_double_ff;
  reg [3:0] status_ff;
  reg ack_ff;
  reg [31:0] rdata_ff;
  reg [31:0] nxt_rdata;
  wire wb_req;
  wire wr_ctrl;
  wire wr_status;
  wire use_single;
  wire use_double;
  wire [3:0] status_set;

  // ----------------------------------------------------------------------
  // Optional pins and the first port's input stage
  // ----------------------------------------------------------------------
  // Absent enables read as always on; an absent reset pin never fires.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      a_en_ff <= 1'b0;
      a_we_ff <= {WE_WIDTH{1'b0}};
      a_addr_ff <= {FIRST_PORT_ADDR_WIDTH{1'b0}};
      a_din_ff <= {DATA_WIDTH{1'b0}};
    end
    else
    begin
      a_en_ff <= first_port_enable | (FIRST_PORT_HAS_ENABLE == 0);
      a_we_ff <= first_port_we;
      a_addr_ff <= first_port_addr;
      a_din_ff <= first_port_din;
    end
  end

  assign a_en = SOFT_IN ? a_en_ff : (first_port_enable | (FIRST_PORT_HAS_ENABLE == 0)); // [RULE17]
  assign a_we = SOFT_IN ? a_we_ff : first_port_we; // [RULE17]
  assign a_addr = SOFT_IN ? a_addr_ff : first_port_addr;
  assign a_din = SOFT_IN ? a_din_ff : first_port_din;
  assign a_regce = first_port_outreg_enable | (FIRST_PORT_HAS_OUTREG_ENABLE == 0);
  assign a_rst = first_port_reset & (FIRST_PORT_HAS_RESET != 0);
  assign b_en = second_port_enable | (SECOND_PORT_HAS_ENABLE == 0); // [RULE6]
  assign b_regce = second_port_outreg_enable | (SECOND_PORT_HAS_OUTREG_ENABLE == 0); // [RULE6]
  assign b_rst = second_port_reset & (SECOND_PORT_HAS_RESET != 0); // [RULE6]

  // ----------------------------------------------------------------------
  // Memory array and write merging
  // ----------------------------------------------------------------------
  assign a_in_range = a_addr < WRITE_DEPTH_A;
  assign b_wr_range = second_port_addr < WRITE_DEPTH_B; // [RULE2] [RULE3]
  assign b_rd_range = second_port_addr < READ_DEPTH_B; // [RULE2]
  assign a_wr = a_en & (|a_we) & a_in_range;
  assign b_wr = b_en & (|second_port_we) & b_wr_range;
  assign a_raw = a_in_range ? mem[a_addr] : {MEM_WIDTH{1'b0}};
  assign b_raw = b_rd_range ? mem[second_port_addr] : {MEM_WIDTH{1'b0}};

  soft_decode #(
    .WIDTH(DATA_WIDTH),
    .ENABLE(SOFT_CORRECTION_SELECT)
  ) u_dec_a (
    .word(a_raw),
    .data(a_old),
    .fixed(a_fixed),
    .double_err(a_double)
  );

  soft_decode #(
    .WIDTH(DATA_WIDTH),
    .ENABLE(SOFT_CORRECTION_SELECT)
  ) u_dec_b (
    .word(b_raw),
    .data(b_old),
    .fixed(b_fixed),
    .double_err(b_double)
  );

  // Both ports share the one byte-write option; a lane covers eight bits.
  genvar i;
  generate
    for (i = 0; i < DATA_WIDTH; i = i + 1)
    begin : g_merge
      localparam LANE = (USE_BYTE_WE != 0) ? ((i / 8) % WE_WIDTH) : 0;
      assign a_new[i] = a_we[LANE] ? a_din[i] : a_old[i]; // [RULE8] [RULE9]
      assign b_new[i] = second_port_we[LANE] ? second_port_din[i] : b_old[i]; // [RULE8] [RULE9]
    end
  endgenerate

  // Injection corrupts the first copy for a single error, both for a double.
  assign use_single = a_wr & arm_single_ff;
  assign use_double = a_wr & arm_double_ff & ~arm_single_ff;
  assign a_enc = {^a_new, a_new[DATA_WIDTH-1:1], a_new[0] ^ use_double,
    ^a_new, a_new[DATA_WIDTH-1:1], a_new[0] ^ (use_single | use_double)}; // [RULE15]
  assign b_enc = {^b_new, b_new, ^b_new, b_new};

  // A first-port write wins when both ports write the same word.
  always @(posedge sys_clk)
  begin
    if (b_wr)
    begin
      mem[second_port_addr] <= b_enc;
    end
    if (a_wr)
    begin
      mem[a_addr] <= a_enc;
    end
  end

  // ----------------------------------------------------------------------
  // Output paths
  // ----------------------------------------------------------------------
  ram_port_out #(
    .WIDTH(DATA_WIDTH),
    .WRITE_MODE(FIRST_PORT_WRITE_MODE),
    .RESET_WINS(FIRST_PORT_RESET_WINS),
    .LATCH_RESET(FIRST_PORT_LATCH_RESET),
    .HAS_OUT_REG(FIRST_PORT_HAS_OUT_REG),
    .INIT(FIRST_PORT_POWERON_VALUE)
  ) u_out_a (
    .sys_clk(sys_clk),
    .rst(rst),
    .port_en(a_en),
    .outreg_en(a_regce),
    .port_rst(a_rst),
    .wr_hit(a_wr),
    .old_data(a_old),
    .new_data(a_new),
    .dout(first_port_dout)
  );

  ram_port_out #(
    .WIDTH(DATA_WIDTH),
    .WRITE_MODE(SECOND_PORT_WRITE_MODE),
    .RESET_WINS(SECOND_PORT_RESET_WINS),
    .LATCH_RESET(SECOND_PORT_LATCH_RESET),
    .HAS_OUT_REG(SECOND_PORT_HAS_OUT_REG),
    .INIT(SECOND_PORT_POWERON_VALUE)
  ) u_out_b (
    .sys_clk(sys_clk),
    .rst(rst),
    .port_en(b_en),
    .outreg_en(b_regce),
    .port_rst(b_rst),
    .wr_hit(b_wr),
    .old_data(b_old),
    .new_data(b_new),
    .dout(b_core_dout)
  );

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      b_dout_ff <= SECOND_PORT_POWERON_VALUE; // [RULE7]
    end
    else
    begin
      b_dout_ff <= b_core_dout;
    end
  end

  assign second_port_dout = SOFT_OUT ? b_dout_ff : b_core_dout; // [RULE17]

  // ----------------------------------------------------------------------
  // Register bus slave
  // ----------------------------------------------------------------------
  assign wb_req = wb_cyc_i & wb_stb_i & ~ack_ff;
  assign wr_ctrl = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_CTRL);
  assign wr_status = wb_req & wb_we_i & wb_sel_i[0] & (wb_adr_i == `OFS_STATUS);
  assign status_set = {b_en & ~b_wr & b_double, b_en & ~b_wr & b_fixed,
    a_en & ~a_wr & a_double, a_en & ~a_wr & a_fixed};

  // Arming a kind the build does not allow is ignored; a new arm beats consumption.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      arm_single_ff <= `ARM_RESET;
      arm_double_ff <= `ARM_RESET;
    end
    else
    begin
      arm_single_ff <= (wr_ctrl & wb_dat_i[`CTRL_ARM_SINGLE] & ERROR_INJECTION_TYPE[0]) |
        (arm_single_ff & ~use_single); // [RULE15]
      arm_double_ff <= (wr_ctrl & wb_dat_i[`CTRL_ARM_DOUBLE] & ERROR_INJECTION_TYPE[1]) |
        (arm_double_ff & ~use_double); // [RULE15]
    end
  end

  // Sticky error flags clear on a written one; a new event wins over the clear.
  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      status_ff <= `STAT_RESET;
    end
    else if (wr_status)
    begin
      status_ff <= status_set | (status_ff & ~wb_dat_i[3:0]);
    end
    else
    begin
      status_ff <= status_set | status_ff;
    end
  end

  always @*
  begin
    nxt_rdata = 32'h0000_0000;
    case (wb_adr_i)
      `OFS_CTRL:
      begin
        nxt_rdata[`CTRL_ARM_SINGLE] = arm_single_ff;
        nxt_rdata[`CTRL_ARM_DOUBLE] = arm_double_ff;
      end
      `OFS_STATUS:
      begin
        nxt_rdata[3:0] = status_ff;
        nxt_rdata[`STAT_PEND_SINGLE] = arm_single_ff;
        nxt_rdata[`STAT_PEND_DOUBLE] = arm_double_ff;
      end
      `OFS_CONFIG:
      begin
        nxt_rdata[`CFG_BYTE_WE] = (USE_BYTE_WE != 0);
        nxt_rdata[`CFG_SOFT] = (SOFT_CORRECTION_SELECT != 0);
        nxt_rdata[`CFG_INJ_LO+1:`CFG_INJ_LO] = ERROR_INJECTION_TYPE;
        nxt_rdata[`CFG_IN_STAGE] = SOFT_IN;
        nxt_rdata[`CFG_OUT_STAGE] = SOFT_OUT;
      end
      default: nxt_rdata = 32'h0000_0000;
    endcase
  end

  always @(posedge sys_clk)
  begin
    if (rst)
    begin
      ack_ff <= 1'b0;
      rdata_ff <= 32'h0000_0000;
    end
    else
    begin
      ack_ff <= wb_req;
      if (wb_req)
      begin
        rdata_ff <= nxt_rdata;
      end
    end
  end

  assign wb_ack_o = ack_ff;
  assign wb_dat_o = rdata_ff;

endmodule // dpram_cfg_top

// [verif/dpram_cfg_asserts.sv]
// Checker of the dual-port memory's bus answer and port output behaviour.
module dpram_cfg_asserts #(
  parameter DATA_WIDTH = 32,
  parameter WE_WIDTH = 4,
  parameter SECOND_PORT_ADDR_WIDTH = 8,
  parameter WRITE_DEPTH_B = 256,
  parameter [DATA_WIDTH-1:0] FIRST_PORT_POWERON_VALUE = {DATA_WIDTH{1'b0}},
  parameter [DATA_WIDTH-1:0] SECOND_PORT_POWERON_VALUE = {DATA_WIDTH{1'b0}}
) (
  input wire sys_clk,
  input wire rst,
  input wire wb_cyc_i,
  input wire wb_stb_i,
  input wire wb_ack_o,
  input wire first_port_enable,
  input wire first_port_outreg_enable,
  input wire first_port_reset,
  input wire [DATA_WIDTH-1:0] first_port_dout,
  input wire second_port_enable,
  input wire second_port_outreg_enable,
  input wire second_port_reset,
  input wire [WE_WIDTH-1:0] second_port_we,
  input wire [SECOND_PORT_ADDR_WIDTH-1:0] second_port_addr,
  input wire [DATA_WIDTH-1:0] second_port_din,
  input wire [DATA_WIDTH-1:0] second_port_dout
);
  timeunit 1ns;
  timeprecision 1ps;
  default clocking @(posedge sys_clk); endclocking
  default disable iff (rst);

  sequence s_b_write;
    second_port_enable && !second_port_reset && (second_port_we == {WE_WIDTH{1'b1}})
      && (second_port_addr < WRITE_DEPTH_B);
  endsequence
  sequence s_b_load;
    second_port_outreg_enable && !second_port_reset;
  endsequence
  sequence s_a_reset;
    first_port_reset && first_port_enable && first_port_outreg_enable;
  endsequence
  sequence s_b_reset;
    second_port_reset && second_port_enable && second_port_outreg_enable;
  endsequence

  a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
    else $error("ack stood longer than one cycle");
  a_ack_latency: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
    else $error("bus request not answered in the next cycle");
  a_poweron_val: assert property ($fell(rst) |-> second_port_dout == SECOND_PORT_POWERON_VALUE)
    else $error("second port output not at power-on value");
  a_write_first: assert property (s_b_write ##1 s_b_load |=> second_port_dout == $past(second_port_din, 2))
    else $error("second port write did not show new data");
  a_latch_two_a: assert property (s_a_reset |=> (first_port_dout == FIRST_PORT_POWERON_VALUE) [*2])
    else $error("first port reset value not held two cycles");
  a_latch_two_b: assert property (s_b_reset |=> (second_port_dout == SECOND_PORT_POWERON_VALUE) [*2])
    else $error("second port reset value not held two cycles");
  a_hold_a: assert property (!first_port_outreg_enable |=> $stable(first_port_dout))
    else $error("first port output moved with register enable low");
  a_hold_b: assert property (!second_port_outreg_enable |=> $stable(second_port_dout))
    else $error("second port output moved with register enable low");
endmodule // dpram_cfg_asserts

bind dpram_cfg_top dpram_cfg_asserts #(
  .DATA_WIDTH(DATA_WIDTH),
  .WE_WIDTH(WE_WIDTH),
  .SECOND_PORT_ADDR_WIDTH(SECOND_PORT_ADDR_WIDTH),
  .WRITE_DEPTH_B(WRITE_DEPTH_B),
  .FIRST_PORT_POWERON_VALUE(FIRST_PORT_POWERON_VALUE),
  .SECOND_PORT_POWERON_VALUE(SECOND_PORT_POWERON_VALUE)
) u_chk (.sys_clk, .rst, .wb_cyc_i, .wb_stb_i, .wb_ack_o, .first_port_enable,
  .first_port_outreg_enable, .first_port_reset, .first_port_dout, .second_port_enable,
  .second_port_outreg_enable, .second_port_reset, .second_port_we, .second_port_addr,
  .second_port_din, .second_port_dout);

// [verif/mem_user.sv]
// User logic model that drives one memory port.
module mem_user #(
  parameter AW = 8,
  parameter DW = 32,
  parameter WW = 4
) (
  input wire sys_clk,
  input wire [DW-1:0] dout,
  output logic en,
  output logic oce,
  output logic prst,
  output logic [WW-1:0] we,
  output logic [AW-1:0] addr,
  output logic [DW-1:0] din
);
  timeunit 1ns;
  timeprecision 1ps;
  initial
  begin
    en = 1'b0;
    oce = 1'b1;
    prst = 1'b0;
    we = '0;
    addr = '0;
    din = '0;
  end
  // One access; the output is sampled once the register has loaded it.
  // Released address and data show the inverse so stale values cannot pass.
  task acc(input logic [WW-1:0] w, input logic [AW-1:0] a, input logic [DW-1:0] d,
    output logic [DW-1:0] q);
    @(posedge sys_clk);
    en <= 1'b1;
    we <= w;
    addr <= a;
    din <= d;
    @(posedge sys_clk);
    en <= 1'b0;
    we <= '0;
    addr <= ~a;
    din <= ~d;
    @(posedge sys_clk);
    @(negedge sys_clk);
    q = dout;
  endtask
  task rst_pulse(input logic e, input logic o);
    @(posedge sys_clk);
    prst <= 1'b1;
    en <= e;
    oce <= o;
    @(posedge sys_clk);
    prst <= 1'b0;
    en <= 1'b0;
    oce <= 1'b1;
  endtask
endmodule // mem_user

// [verif/dpram_cfg_top_tb_top.sv]
// Self-checking testbench of the configurable dual-port memory.
`include "dpram_cfg_defines.vh"
module dpram_cfg_top_tb_top;
  timeunit 1ns;
  timeprecision 1ps;
  localparam [31:0] INIT_A = 32'h1234_5678;
  localparam [31:0] INIT_B = 32'hA5A5_5A5A;
  logic sys_clk, rst, wb_cyc_i, wb_stb_i, wb_we_i;
  logic [7:0] wb_adr_i;
  logic [3:0] wb_sel_i;
  logic [31:0] wb_dat_i, q;
  wire [31:0] wb_dat_o, a_dout, b_dout, a_din, b_din;
  wire wb_ack_o, a_en, a_oce, a_rst, b_en, b_oce, b_rst;
  wire [3:0] a_we, b_we;
  wire [7:0] a_adr, b_adr;
  int bad_count, check_count;

  dpram_cfg_top #(.WRITE_DEPTH_B(128), .READ_DEPTH_B(128), .FIRST_PORT_POWERON_VALUE(INIT_A),
    .SECOND_PORT_POWERON_VALUE(INIT_B), .ERROR_INJECTION_TYPE(`INJ_BOTH),
    .SOFT_CORRECTION_SELECT(1)) i_dut (.sys_clk(sys_clk), .rst(rst), .wb_cyc_i(wb_cyc_i),
    .wb_stb_i(wb_stb_i), .wb_we_i(wb_we_i), .wb_adr_i(wb_adr_i), .wb_sel_i(wb_sel_i),
    .wb_dat_i(wb_dat_i), .wb_dat_o(wb_dat_o), .wb_ack_o(wb_ack_o),
    .first_port_enable(a_en), .first_port_outreg_enable(a_oce), .first_port_reset(a_rst),
    .first_port_we(a_we), .first_port_addr(a_adr), .first_port_din(a_din),
    .first_port_dout(a_dout), .second_port_enable(b_en), .second_port_outreg_enable(b_oce),
    .second_port_reset(b_rst), .second_port_we(b_we), .second_port_addr(b_adr),
    .second_port_din(b_din), .second_port_dout(b_dout));
  mem_user u_a (.sys_clk(sys_clk), .dout(a_dout), .en(a_en), .oce(a_oce), .prst(a_rst),
    .we(a_we), .addr(a_adr), .din(a_din));
  mem_user u_b (.sys_clk(sys_clk), .dout(b_dout), .en(b_en), .oce(b_oce), .prst(b_rst),
    .we(b_we), .addr(b_adr), .din(b_din));

  task chk(input logic [31:0] got, input logic [31:0] exp);
    check_count++;
    if (got !== exp)
    begin
      $display("[FAIL] %0t got %h expected %h", $time, got, exp);
      bad_count++;
    end
  endtask
  task wb(input logic w, input logic [7:0] a, input logic [31:0] d);
    int n;
    n = 0;
    @(posedge sys_clk);
    wb_cyc_i <= 1'b1;
    wb_stb_i <= 1'b1;
    wb_we_i <= w;
    wb_adr_i <= a;
    wb_dat_i <= d;
    @(posedge sys_clk);
    while (wb_ack_o !== 1'b1 && n < 20)
    begin
      @(posedge sys_clk);
      n++;
    end
    if (n == 20)
    begin
      $display("[FAIL] %0t got %h expected %h", $time, wb_ack_o, 1'b1);
      bad_count++;
    end
    q = wb_dat_o;
    wb_cyc_i <= 1'b0;
    wb_stb_i <= 1'b0;
    wb_adr_i <= ~a;
    wb_dat_i <= ~d;
    @(posedge sys_clk);
  endtask
  task t_regs;
    chk(b_dout, INIT_B);
    wb(1'b1, `OFS_CONFIG, 32'h0000_0000);
    wb(1'b0, `OFS_CONFIG, 32'h0000_0000);
    chk(q, 32'h0000_000F);
    wb(1'b0, 8'h0C, 32'h0000_0000);
    chk(q, 32'h0000_0000);
    wb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask
  task t_ports;
    u_a.acc(4'hF, 8'h10, 32'hCAFE_0001, q);
    u_b.acc(4'h0, 8'h10, 32'h0000_0000, q);
    chk(q, 32'hCAFE_0001);
    u_b.acc(4'hF, 8'h11, 32'h1111_2222, q);
    chk(q, 32'h1111_2222);
    u_b.acc(4'h4, 8'h11, 32'hAABB_CCDD, q);
    chk(q, 32'h11BB_2222);
    u_a.acc(4'hF, 8'hC8, 32'h5555_AAAA, q);
    u_b.acc(4'h0, 8'hC8, 32'h0000_0000, q);
    chk(q, 32'h0000_0000);
    u_a.acc(4'hF, 8'h90, 32'h3333_4444, q);
    u_b.acc(4'hF, 8'h90, 32'h7777_7777, q);
    u_a.acc(4'h0, 8'h90, 32'h0000_0000, q);
    chk(q, 32'h3333_4444);
  endtask
  task t_reset;
    u_b.acc(4'h0, 8'h11, 32'h0000_0000, q);
    u_b.rst_pulse(1'b1, 1'b1);
    @(negedge sys_clk);
    chk(b_dout, INIT_B);
    @(negedge sys_clk);
    chk(b_dout, INIT_B);
    u_b.acc(4'h0, 8'h11, 32'h0000_0000, q);
    u_b.rst_pulse(1'b1, 1'b0);
    @(negedge sys_clk);
    chk(b_dout, 32'h11BB_2222);
    @(negedge sys_clk);
    chk(b_dout, INIT_B);
    // Port A is left on a written word, so its enabled reset cycle reads no unset memory.
    u_a.acc(4'hF, 8'hEE, 32'h2468_ACE0, q);
    u_a.rst_pulse(1'b1, 1'b1);
    @(negedge sys_clk);
    chk(a_dout, INIT_A);
  endtask
  task t_inject;
    wb(1'b1, `OFS_CTRL, 32'h0000_0001);
    u_a.acc(4'hF, 8'h20, 32'h0F0F_0F0F, q);
    u_b.acc(4'h0, 8'h20, 32'h0000_0000, q);
    chk(q, 32'h0F0F_0F0F);
    wb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0004);
    wb(1'b1, `OFS_CTRL, 32'h0000_0002);
    u_a.acc(4'hF, 8'h21, 32'h0F0F_0F0F, q);
    u_b.acc(4'h0, 8'h21, 32'h0000_0000, q);
    // A double error cannot be corrected, so the damaged second copy shows.
    chk(q, 32'h0F0F_0F0E);
    wb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_000C);
    wb(1'b1, `OFS_STATUS, 32'h0000_000F);
    wb(1'b0, `OFS_STATUS, 32'h0000_0000);
    chk(q, 32'h0000_0000);
  endtask
  task give_verdict;
    if (bad_count == 0 && check_count > 0)
      $display("No errors found");
    else
      $display("Errors were found");
    $finish;
  endtask

  initial
  begin
    sys_clk = 1'b0;
    forever #10 sys_clk = ~sys_clk;
  end
  initial
  begin
    rst = 1'b1;
    wb_cyc_i = 1'b0;
    wb_stb_i = 1'b0;
    wb_we_i = 1'b0;
    wb_adr_i = 8'h00;
    wb_sel_i = 4'hF;
    wb_dat_i = 32'h0000_0000;
    repeat (5) @(posedge sys_clk);
    rst <= 1'b0;
    t_regs;
    t_ports;
    t_reset;
    t_inject;
    give_verdict;
  end
  initial
  begin
    #100000;
    bad_count++;
    give_verdict;
  end
endmodule // dpram_cfg_top_tb_top
